/* File: dv/pcd_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// serial host driving register frames
module pcd_host_model (
  // clock
  input  wire logic core_clk,
  // serial pins
  output logic      sen_n,
  output logic      sclk,
  output logic      mosi,
  output logic      mosi_oe,
  input  wire logic sdio_w,
  input  wire logic serial_data_out,
  input  wire logic serial_data_out_oe,
  input  wire logic sdio_oe,
  input  wire logic bidir
);
  // bit reversal of one byte
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7-i];
  endfunction
  // idle pins
  initial begin
    {sen_n, sclk, mosi, mosi_oe} = 4'b1001;
  end
  // frame of nb bits, rd data out
  task automatic xfer(input logic rd, input logic two, input logic [5:0] adr,
                      input logic [15:0] wd, input logic lsb, input int nb,
                      output logic [15:0] q);
    logic [23:0] f;
    logic [23:0] c;
    f = {rd, two, adr, wd};
    if (lsb) f = {rev(f[23:16]), rev(f[15:8]), rev(f[7:0])};
    @(negedge core_clk) sen_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      mosi = f[23-i];
      sclk = 1'b1;
      @(negedge core_clk);
      // free shared pin after last instruction bit
      if (rd && bidir && i == 7) mosi_oe = 1'b0;
      @(negedge core_clk);
      sclk = 1'b0;
      repeat (5) @(negedge core_clk);
      // take the pin in use; unknown if undriven
      c[23-i] = (bidir ? sdio_oe : serial_data_out_oe) ?
                (bidir ? sdio_w : serial_data_out) : 1'bx;
    end
    sen_n = 1'b1;
    mosi_oe = 1'b1;
    repeat (3) @(negedge core_clk);
    q = c[16:1];
    if (lsb) q = {rev(q[15:8]), rev(q[7:0])};
  endtask
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// register and clock path bench
module testbench;
  import pcd_pkg::*;
  logic         core_clk, srst, sen_n, sclk, mosi, mosi_oe;
  logic         sdio_out, sdio_oe, ser_out, ser_out_oe, lsb, bidir, aux_en, fd;
  logic         rx_ref, tx_ref, pll, aux_nrm, adc_o, rxp_o, txp_o, aux_o;
  wire logic    sdio_in;
  pcd_clk_cfg_s cfg;
  int           failures, n_checks, cyc, n_adc, n_rx, n_tx, n_aux;
  logic [3:0]   prv;
  logic [15:0]  q;
  // shared data wire; undriven shows inverse
  assign sdio_in = sdio_oe ? sdio_out : (mosi_oe ? mosi : ~mosi);
  pcd_host_model host (.core_clk(core_clk), .sen_n(sen_n), .sclk(sclk), .mosi(mosi),
    .mosi_oe(mosi_oe), .sdio_w(sdio_in), .serial_data_out(ser_out),
    .serial_data_out_oe(ser_out_oe), .sdio_oe(sdio_oe), .bidir(bidir));
  pcd_clock_config DUT (.core_clk(core_clk), .srst(srst), .sen_n(sen_n), .sclk(sclk),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_data_out(ser_out),
    .serial_data_out_oe(ser_out_oe), .lsb_first_mode(lsb), .sdio_bidir_mode(bidir),
    .aux_iface_enable(aux_en), .full_duplex_mode(fd), .rx_ref_clk_in(rx_ref),
    .tx_ref_clk_in(tx_ref), .pll_clk_in(pll), .aux_iface_normal_clk(aux_nrm),
    .clk_cfg(cfg), .adc_clk_out(adc_o), .rx_path_clk_out(rxp_o),
    .tx_path_clk_out(txp_o), .aux_interface_clock_out(aux_o));
  // core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // reference clocks: rx /6, tx /8, pll /2, aux /14
  initial begin
    {cyc, rx_ref, tx_ref, pll, aux_nrm} = '0;
    forever begin
      @(negedge core_clk);
      cyc++;
      pll = ~pll;
      if (cyc % 3 == 0) rx_ref = ~rx_ref;
      if (cyc % 4 == 0) tx_ref = ~tx_ref;
      if (cyc % 7 == 0) aux_nrm = ~aux_nrm;
    end
  end
  // rising edge counters of derived clocks
  always @(posedge core_clk) begin
    prv <= {adc_o, rxp_o, txp_o, aux_o};
    if (adc_o && !prv[3]) n_adc++;
    if (rxp_o && !prv[2]) n_rx++;
    if (txp_o && !prv[1]) n_tx++;
    if (aux_o && !prv[0]) n_aux++;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic near(input string nm, input int e, input int g);
    n_checks++;
    if (g < e - 1 || g > e + 1) begin
      failures++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wr1(input logic [5:0] a, input logic [7:0] d);
    host.xfer(1'b0, 1'b0, a, {d, 8'h00}, lsb, 16, q);
  endtask
  task automatic rd1(input logic [5:0] a, input logic [7:0] e);
    host.xfer(1'b1, 1'b0, a, 16'h0000, lsb, 16, q);
    chk("read", {8'h00, e}, {8'h00, q[15:8]});
  endtask
  // program both registers, then count edges over 400 cycles
  task automatic clk_case(input logic [7:0] r15, input logic [7:0] r16, input logic en,
                          input logic f, input int ea, input int er, input int et,
                          input int ex);
    host.xfer(1'b0, 1'b1, PCD_ADDR_ROUTE_SETUP, {r16, r15}, 1'b0, 24, q);
    aux_en = en;
    fd = f;
    repeat (10) @(negedge core_clk);
    {n_adc, n_rx, n_tx, n_aux} = 128'd0;
    repeat (400) @(negedge core_clk);
    near("adc_clk", ea, n_adc);
    near("rx_clk", er, n_rx);
    near("tx_clk", et, n_tx);
    near("aux_clk", ex, n_aux);
    $display("test clock case %h %h done", r15, r16);
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    complete_run();
  end
  initial begin
    {srst, lsb, bidir, aux_en, fd} = 5'b10000;
    {failures, n_checks} = 64'd0;
    repeat (20) @(negedge core_clk);
    srst = 1'b0;
    chk("cfg reset", 16'h0080, {7'h00, cfg});
    rd1(PCD_ADDR_PLL_SETUP, 8'h00);
    rd1(PCD_ADDR_ROUTE_SETUP, 8'h00);
    rd1(6'h2a, 8'h00);
    wr1(PCD_ADDR_PLL_SETUP, 8'hfc);
    rd1(PCD_ADDR_PLL_SETUP, 8'hbc);
    chk("cfg all set", 16'h01ce, {7'h00, cfg});
    for (int m = 0; m < 5; m++) begin
      wr1(PCD_ADDR_PLL_SETUP, 8'(m));
      chk("mult", 16'(m), {13'h0000, cfg.mult});
    end
    $display("test registers done");
    lsb = 1'b1;
    host.xfer(1'b0, 1'b1, PCD_ADDR_PLL_SETUP, 16'h0824, 1'b1, 24, q);
    rd1(PCD_ADDR_PLL_SETUP, 8'h08);
    lsb = 1'b0;
    host.xfer(1'b1, 1'b1, PCD_ADDR_ROUTE_SETUP, 16'h0000, 1'b0, 24, q);
    chk("dual read", 16'h2408, q);
    chk("slow fifth", 16'h0003, {14'h0000, cfg.slow_loop, cfg.fifth});
    bidir = 1'b1;
    rd1(PCD_ADDR_ROUTE_SETUP, 8'h24);
    bidir = 1'b0;
    host.xfer(1'b0, 1'b0, PCD_ADDR_ROUTE_SETUP, 16'h0000, 1'b0, 12, q);
    rd1(PCD_ADDR_ROUTE_SETUP, 8'h24);
    wr1(PCD_ADDR_ROUTE_SETUP, 8'hdb);
    rd1(PCD_ADDR_ROUTE_SETUP, 8'h00);
    $display("test serial port done");
    clk_case(8'h00, 8'h00, 1'b0, 1'b0, 67, 67, 200, 29);
    clk_case(8'h20, 8'h00, 1'b0, 1'b0, 33, 67, 200, 29);
    clk_case(8'h10, 8'h00, 1'b0, 1'b0, 200, 200, 200, 29);
    clk_case(8'h30, 8'h00, 1'b0, 1'b0, 100, 200, 200, 29);
    clk_case(8'h18, 8'h00, 1'b0, 1'b0, 40, 40, 40, 29);
    clk_case(8'h98, 8'h00, 1'b0, 1'b0, 50, 50, 50, 29);
    clk_case(8'h00, 8'h20, 1'b0, 1'b0, 67, 67, 200, 29);
    clk_case(8'h00, 8'h20, 1'b1, 1'b0, 67, 67, 200, 200);
    clk_case(8'h08, 8'h20, 1'b0, 1'b1, 67, 67, 40, 40);
    complete_run();
  end
endmodule
`default_nettype wire

/* File: src/pcd_clock_config.sv */
// Summary of operation
// RULE1 - bypass routes reference around running PLL
// RULE2 - ADC source: rx reference or PLL
// RULE3 - ADC divide bit halves source, default off
// RULE4 - alternative timing clocks receive path from PLL
// RULE5 - divide-by-five bit divides PLL output
// RULE6 - multiplier field selects 1x to 16x
// RULE7 - host never writes multiplier codes 101-111
// RULE8 - PLL output from multiplier and divider
// RULE9 - routing bit puts PLL on aux output
// RULE10 - aux routing needs reg01 bit2 or FD
// RULE11 - slow-loop bit selects alternate loop bandwidth
// RULE12 - serial read/write, one/two bytes, either order
// RULE13 - serial data on one or two pins
// RULE14 - rx ref feeds rx path, tx ref tx; here the tx path takes the PLL path, which is tx ref only when bypassed
// RULE15 - unused bits zero, defaults low after reset
`timescale 1ns/1ns
`default_nettype none
module pcd_clock_config (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  // serial register port
  input  wire logic              sen_n,
  input  wire logic              sclk,
  input  wire logic              sdio_in,
  output logic                   sdio_out,
  output logic                   sdio_oe,
  output logic                   serial_data_out,
  output logic                   serial_data_out_oe,
  // serial port modes
  input  wire logic              lsb_first_mode,
  input  wire logic              sdio_bidir_mode,
  // interface mode levels
  input  wire logic              aux_iface_enable,
  input  wire logic              full_duplex_mode,
  // reference and pll clocks
  input  wire logic              rx_ref_clk_in,
  input  wire logic              tx_ref_clk_in,
  input  wire logic              pll_clk_in,
  input  wire logic              aux_iface_normal_clk,
  // configuration and derived clocks
  output pcd_pkg::pcd_clk_cfg_s  clk_cfg,
  output logic                   adc_clk_out,
  output logic                   rx_path_clk_out,
  output logic                   tx_path_clk_out,
  output logic                   aux_interface_clock_out
);
  import pcd_pkg::*;

  // ==========================================================
  // serial port and registers
  logic [7:0] r15_ff, nxt_r15;       // pll_clock_setup
  logic [7:0] r16_ff, nxt_r16;       // clock_routing_setup
  logic       sclk_ff, sclk_prev_ff; // sampled serial clock
  logic       sen_n_ff, sdi_ff;      // sampled enable and data
  pcd_spi_e   st_ff, nxt_st;         // frame phase
  logic [4:0] cnt_ff, nxt_cnt;       // rising edges in frame
  logic [7:0] sh_ff, nxt_sh;         // input shifter
  logic [7:0] tx_ff, nxt_tx;         // output shifter
  logic [7:0] b1_ff, nxt_b1;         // first byte of dual write
  logic [5:0] adr_ff, nxt_adr;       // current address
  logic       two_ff, nxt_two;       // dual byte frame
  logic       rd_ff, nxt_rd;         // read frame
  logic       dout_ff, nxt_dout;     // serial output bit
  logic       sclk_rise, sclk_fall;
  logic       wa_en, wb_en;          // write strobes
  logic [5:0] wa_adr, wb_adr;
  logic [7:0] wa_dat, wb_dat;
  logic [5:0] adr_next;              // second byte address

  assign sclk_rise = sclk_ff & ~sclk_prev_ff;
  assign sclk_fall = ~sclk_ff & sclk_prev_ff;
  assign adr_next  = lsb_first_mode ? adr_ff + 6'h01 : adr_ff - 6'h01;

  // readback with unused bits forced low
  function automatic logic [7:0] pcd_rd(input logic [5:0] a, input logic [7:0] x,
                                       input logic [7:0] y);
    if (a == PCD_ADDR_PLL_SETUP) begin
      return x & PCD_MASK_PLL_SETUP;
    end else if (a == PCD_ADDR_ROUTE_SETUP) begin
      return y & PCD_MASK_ROUTE_SETUP;
    end
    return 8'h00;
  endfunction

  // frame decode, shifting and register writes
  always_comb begin
    nxt_st = st_ff; nxt_cnt = cnt_ff; nxt_sh = sh_ff; nxt_tx = tx_ff;
    nxt_b1 = b1_ff; nxt_adr = adr_ff; nxt_two = two_ff; nxt_rd = rd_ff;
    nxt_dout = dout_ff; nxt_r15 = r15_ff; nxt_r16 = r16_ff;
    wa_en = 1'b0; wb_en = 1'b0; wa_adr = adr_ff; wb_adr = adr_next;
    wa_dat = 8'h00; wb_dat = 8'h00;
    if (sen_n_ff) begin
      // idle: partial frames are dropped
      nxt_st = PCD_INSTR; nxt_cnt = 5'h00; nxt_rd = 1'b0;
    end else begin
      if (sclk_rise) begin
        // RULE12 bit order
        nxt_sh = lsb_first_mode ? {sdi_ff, sh_ff[7:1]} : {sh_ff[6:0], sdi_ff};
        if (cnt_ff != PCD_FRAME_END) begin
          nxt_cnt = cnt_ff + 5'h01;
        end
        unique case (st_ff)
          PCD_INSTR: if (cnt_ff == PCD_LAST_INSTR) begin
            // instruction: read flag, byte count, address
            nxt_rd = nxt_sh[7]; nxt_two = nxt_sh[6]; nxt_adr = nxt_sh[5:0];
            nxt_st = nxt_sh[7] ? PCD_READ : PCD_WRITE;
            nxt_tx = pcd_rd(nxt_sh[5:0], r15_ff, r16_ff);
          end
          PCD_WRITE: if (cnt_ff == PCD_LAST_BYTE1) begin
            // RULE12 single byte commits here
            if (two_ff) begin
              nxt_b1 = nxt_sh;
            end else begin
              wa_en = 1'b1; wa_dat = nxt_sh; nxt_st = PCD_HOLD;
            end
          end else if (cnt_ff == PCD_LAST_BYTE2) begin
            // dual write commits both bytes together
            wa_en = 1'b1; wa_dat = b1_ff;
            wb_en = 1'b1; wb_dat = nxt_sh; nxt_st = PCD_HOLD;
          end
          PCD_READ: if (cnt_ff == PCD_LAST_BYTE1) begin
            if (two_ff) begin
              nxt_adr = adr_next;
              nxt_tx = pcd_rd(adr_next, r15_ff, r16_ff);
            end else begin
              nxt_st = PCD_HOLD;
            end
          end else if (cnt_ff == PCD_LAST_BYTE2) begin
            nxt_st = PCD_HOLD;
          end
          PCD_HOLD: nxt_st = PCD_HOLD;
        endcase
      end
      if (sclk_fall && st_ff == PCD_READ) begin
        // output bit changes on falling edge
        nxt_dout = lsb_first_mode ? tx_ff[0] : tx_ff[7];
        nxt_tx = lsb_first_mode ? {1'b0, tx_ff[7:1]} : {tx_ff[6:0], 1'b0};
      end
    end
    // RULE15 masked storage
    if (wa_en && wa_adr == PCD_ADDR_PLL_SETUP)   nxt_r15 = wa_dat & PCD_MASK_PLL_SETUP;
    if (wa_en && wa_adr == PCD_ADDR_ROUTE_SETUP) nxt_r16 = wa_dat & PCD_MASK_ROUTE_SETUP;
    if (wb_en && wb_adr == PCD_ADDR_PLL_SETUP)   nxt_r15 = wb_dat & PCD_MASK_PLL_SETUP;
    if (wb_en && wb_adr == PCD_ADDR_ROUTE_SETUP) nxt_r16 = wb_dat & PCD_MASK_ROUTE_SETUP;
  end

  // serial and register flops
  always_ff @(posedge core_clk) begin
    if (srst) begin
      // RULE15 defaults low
      r15_ff <= PCD_RST_PLL_SETUP; r16_ff <= PCD_RST_ROUTE_SETUP;
      sclk_ff <= 1'b0; sclk_prev_ff <= 1'b0; sen_n_ff <= 1'b1; sdi_ff <= 1'b0;
      st_ff <= PCD_INSTR; cnt_ff <= 5'h00; sh_ff <= 8'h00; tx_ff <= 8'h00;
      b1_ff <= 8'h00; adr_ff <= 6'h00; two_ff <= 1'b0; rd_ff <= 1'b0;
      dout_ff <= 1'b0;
    end else begin
      r15_ff <= nxt_r15; r16_ff <= nxt_r16;
      sclk_ff <= sclk; sclk_prev_ff <= sclk_ff; sen_n_ff <= sen_n; sdi_ff <= sdio_in;
      st_ff <= nxt_st; cnt_ff <= nxt_cnt; sh_ff <= nxt_sh; tx_ff <= nxt_tx;
      b1_ff <= nxt_b1; adr_ff <= nxt_adr; two_ff <= nxt_two; rd_ff <= nxt_rd;
      dout_ff <= nxt_dout;
    end
  end

  // RULE13 three-wire or four-wire readback
  assign sdio_out           = dout_ff;
  assign serial_data_out    = dout_ff;
  assign sdio_oe            = rd_ff & ~sen_n_ff & sdio_bidir_mode;
  assign serial_data_out_oe = rd_ff & ~sen_n_ff & ~sdio_bidir_mode;

  // ==========================================================
  // clock selection and division
  logic       rx_ff, txr_ff, pll_ff, pll_prev_ff;  // sampled clocks
  logic       src_prev_ff, nxt_src_prev;           // adc source history
  logic [2:0] div_ff, nxt_div;                     // fifth counter
  logic       fifth_ff, nxt_fifth;                 // pll over five
  logic       half_ff, nxt_half;                   // adc source over two
  logic       adc_ff, rxc_ff, txc_ff, aux_ff;      // output clocks
  logic       nxt_adc, nxt_rxc, nxt_txc, nxt_aux;
  logic       pll_path, adc_src, aux_ok;

  // RULE6 RULE11 configuration to the analog pll
  assign clk_cfg.bypass      = r15_ff[PCD_BIT_BYPASS];
  assign clk_cfg.pll_keep_on = 1'b1;
  assign clk_cfg.mult        = r15_ff[PCD_MULT_MSB:PCD_MULT_LSB];
  assign clk_cfg.fifth       = r15_ff[PCD_BIT_FIFTH];
  assign clk_cfg.alt_timing  = r15_ff[PCD_BIT_ALT_TIME];
  assign clk_cfg.adc_div2    = r15_ff[PCD_BIT_ADC_DIV2];
  assign clk_cfg.slow_loop   = r16_ff[PCD_BIT_SLOW];

  // RULE1 RULE8 pll path, reference when bypassed
  assign pll_path = clk_cfg.bypass ? txr_ff : (clk_cfg.fifth ? fifth_ff : pll_ff);
  // RULE2 RULE14 adc source
  assign adc_src  = clk_cfg.alt_timing ? pll_path : rx_ff;
  // RULE10 aux routing qualifier
  assign aux_ok   = r16_ff[PCD_BIT_AUX_PLL] & (aux_iface_enable | full_duplex_mode);

  // dividers and output muxes
  always_comb begin
    nxt_div = div_ff; nxt_fifth = fifth_ff; nxt_half = half_ff;
    nxt_src_prev = adc_src;
    // RULE5 count pll rising edges modulo five
    if (pll_ff && !pll_prev_ff) begin
      nxt_div = (div_ff == PCD_FIFTH_LAST) ? 3'h0 : div_ff + 3'h1;
      nxt_fifth = (nxt_div < PCD_FIFTH_HIGH);
    end
    // RULE3 toggle on adc source rising edge
    if (adc_src && !src_prev_ff) begin
      nxt_half = ~half_ff;
    end
    nxt_adc = clk_cfg.adc_div2 ? half_ff : adc_src;
    // RULE4 receive path source
    nxt_rxc = adc_src;
    // RULE14 transmit path from pll or its reference
    nxt_txc = pll_path;
    // RULE9 aux output carries pll clock when aux_ok, else normal clock
    nxt_aux = aux_ok ? pll_path : aux_iface_normal_clk;
  end

  // clock flops
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_ff <= 1'b0; txr_ff <= 1'b0; pll_ff <= 1'b0; pll_prev_ff <= 1'b0;
      src_prev_ff <= 1'b0; div_ff <= 3'h0; fifth_ff <= 1'b0; half_ff <= 1'b0;
      adc_ff <= 1'b0; rxc_ff <= 1'b0; txc_ff <= 1'b0; aux_ff <= 1'b0;
    end else begin
      rx_ff <= rx_ref_clk_in; txr_ff <= tx_ref_clk_in;
      pll_ff <= pll_clk_in; pll_prev_ff <= pll_ff;
      src_prev_ff <= nxt_src_prev; div_ff <= nxt_div; fifth_ff <= nxt_fifth;
      half_ff <= nxt_half; adc_ff <= nxt_adc; rxc_ff <= nxt_rxc;
      txc_ff <= nxt_txc; aux_ff <= nxt_aux;
    end
  end

  assign adc_clk_out             = adc_ff;
  assign rx_path_clk_out         = rxc_ff;
  assign tx_path_clk_out         = txc_ff;
  assign aux_interface_clock_out = aux_ff;

  // ==========================================================
  // checks
  property p_bypass_tx;
    @(posedge core_clk) disable iff (srst)
    clk_cfg.bypass |=> txc_ff == $past(txr_ff);
  endproperty
  a_bypass_tx: assert property (p_bypass_tx) else $error("bypass not on tx"); // RULE1

  property p_adc_normal;
    @(posedge core_clk) disable iff (srst)
    (!clk_cfg.alt_timing && !clk_cfg.adc_div2) |=> adc_ff == $past(rx_ff);
  endproperty
  a_adc_normal: assert property (p_adc_normal) else $error("adc not from rx ref"); // RULE2

  property p_half_toggle;
    @(posedge core_clk) disable iff (srst)
    (adc_src && !src_prev_ff) |=> half_ff != $past(half_ff);
  endproperty
  a_half_toggle: assert property (p_half_toggle) else $error("halver missed edge"); // RULE3

  property p_alt_rx;
    @(posedge core_clk) disable iff (srst)
    clk_cfg.alt_timing |=> rxc_ff == $past(pll_path);
  endproperty
  a_alt_rx: assert property (p_alt_rx) else $error("rx path not from pll"); // RULE4

  property p_fifth_wrap;
    @(posedge core_clk) disable iff (srst)
    (pll_ff && !pll_prev_ff && div_ff == PCD_FIFTH_LAST) |=> div_ff == 3'h0 && fifth_ff;
  endproperty
  a_fifth_wrap: assert property (p_fifth_wrap) else $error("fifth count wrong"); // RULE5

  property p_aux_gate;
    @(posedge core_clk) disable iff (srst)
    !(aux_iface_enable || full_duplex_mode) |=> aux_ff == $past(aux_iface_normal_clk);
  endproperty
  a_aux_gate: assert property (p_aux_gate) else $error("aux routed ungated"); // RULE10

  property p_write_one;
    @(posedge core_clk) disable iff (srst)
    (!sen_n_ff && sclk_rise && st_ff == PCD_WRITE && !two_ff && cnt_ff == PCD_LAST_BYTE1
     && adr_ff == PCD_ADDR_PLL_SETUP) |=> r15_ff == ($past(nxt_sh) & PCD_MASK_PLL_SETUP);
  endproperty
  a_write_one: assert property (p_write_one) else $error("write not stored"); // RULE12

  property p_one_driver;
    @(posedge core_clk) disable iff (srst)
    !(sdio_oe && serial_data_out_oe);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("both data pins driven"); // RULE13

  property p_reset_vals;
    @(posedge core_clk)
    srst |=> r15_ff == PCD_RST_PLL_SETUP && r16_ff == PCD_RST_ROUTE_SETUP;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong"); // RULE15
endmodule
`default_nettype wire

/* File: src/pcd_pkg.sv */
// ============================================================
// clock distribution configuration constants
`default_nettype none
package pcd_pkg;
  // register addresses on the serial port
  localparam logic [5:0] PCD_ADDR_PLL_SETUP   = 6'h15;
  localparam logic [5:0] PCD_ADDR_ROUTE_SETUP = 6'h16;
  // reset values
  localparam logic [7:0] PCD_RST_PLL_SETUP    = 8'h00;
  localparam logic [7:0] PCD_RST_ROUTE_SETUP  = 8'h00;
  // implemented bits; the rest read as zero
  localparam logic [7:0] PCD_MASK_PLL_SETUP   = 8'hbf;
  localparam logic [7:0] PCD_MASK_ROUTE_SETUP = 8'h24;
  // pll_clock_setup fields
  localparam int PCD_BIT_BYPASS   = 7;
  localparam int PCD_BIT_ADC_DIV2 = 5;
  localparam int PCD_BIT_ALT_TIME = 4;
  localparam int PCD_BIT_FIFTH    = 3;
  localparam int PCD_MULT_MSB     = 2;
  localparam int PCD_MULT_LSB     = 0;
  // clock_routing_setup fields
  localparam int PCD_BIT_AUX_PLL  = 5;
  localparam int PCD_BIT_SLOW     = 2;
  // serial frame bit counts
  localparam logic [4:0] PCD_LAST_INSTR = 5'h07;
  localparam logic [4:0] PCD_LAST_BYTE1 = 5'h0f;
  localparam logic [4:0] PCD_LAST_BYTE2 = 5'h17;
  localparam logic [4:0] PCD_FRAME_END  = 5'h18;
  // divide-by-five counter
  localparam logic [2:0] PCD_FIFTH_LAST = 3'h4;
  localparam logic [2:0] PCD_FIFTH_HIGH = 3'h2;
  // serial port phase
  typedef enum logic [1:0] {PCD_INSTR, PCD_WRITE, PCD_READ, PCD_HOLD} pcd_spi_e;
  // decoded configuration towards the analog pll
  typedef struct packed {
    logic       bypass;
    logic       pll_keep_on;
    logic [2:0] mult;
    logic       fifth;
    logic       alt_timing;
    logic       adc_div2;
    logic       slow_loop;
  } pcd_clk_cfg_s;
endpackage
`default_nettype wire
